// file: ianc_pkg.sv
`default_nettype none
package ianc_pkg;
    // register byte offsets
    localparam int              ADDR_W          = 8;
    localparam logic [7:0]      OFS_ABORT_CAUSE = 8'h80;
    localparam logic [7:0]      OFS_FORCE_NACK  = 8'h84;
    localparam logic [7:0]      OFS_DMA_EN      = 8'h88;
    localparam logic [7:0]      OFS_TX_WM       = 8'h8c;
    localparam logic [7:0]      OFS_RX_WM       = 8'h90;
    localparam logic [7:0]      OFS_IRQ_STATUS  = 8'ha0;
    localparam logic [7:0]      OFS_IRQ_MASK    = 8'ha4;
    // abort cause bit positions
    localparam int              CAUSE_LSB       = 8;
    localparam int              CAUSE_MSB       = 15;
    localparam int              BIT_TEN_BIT_RD  = 8;
    localparam int              BIT_MST_OFF     = 9;
    localparam int              BIT_ARB_LOST    = 10;
    localparam int              BIT_STALE_FLUSH = 11;
    localparam int              BIT_SLV_ARB     = 12;
    localparam int              BIT_SLV_RD_DONE = 13;
    localparam int              BIT_SLV_BUS     = 14;
    localparam int              BIT_SLV_CMD_WR  = 15;
    // control field positions and widths
    localparam int              BIT_FORCE_NACK  = 0;
    localparam int              BIT_RX_DMA_ON   = 0;
    localparam int              BIT_TX_DMA_ON   = 1;
    localparam int              WM_W            = 3;
    localparam int              IRQ_W           = 2;
    localparam int              BIT_IRQ_ABORT   = 0;
    localparam int              BIT_IRQ_NACK    = 1;
    // values after reset
    localparam logic [7:0]      RST_ABORT_CAUSE = 8'h00;
    localparam logic            RST_FORCE_NACK  = 1'h0;
    localparam logic [1:0]      RST_DMA_EN      = 2'h0;
    localparam logic [2:0]      RST_WM          = 3'h0;
    localparam logic [1:0]      RST_IRQ         = 2'h0;
    // bus responses
    localparam logic [1:0]      RESP_OKAY       = 2'h0;
    localparam logic [1:0]      RESP_SLVERR     = 2'h2;
    // acknowledge slot sequencing
    typedef enum logic [1:0] {
        ACK_IDLE,
        ACK_WAIT_HIGH,
        ACK_WAIT_LOW
    } ianc_ack_state_type;
endpackage
`default_nettype wire

// file: ianc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module ianc_ctrl
    import ianc_pkg::*;
#(
    parameter int LEVEL_W = 4
) (
    // clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic [2:0]         s_axi_awprot,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    // axi4-lite write response
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0]  s_axi_araddr,
    input  wire logic [2:0]         s_axi_arprot,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // core events and state, same clock
    input  wire logic               repeated_start_allow,
    input  wire logic               master_enable,
    input  wire logic               ten_bit_read_req,
    input  wire logic               master_start_req,
    input  wire logic               master_arb_lost,
    input  wire logic               slave_read_req,
    input  wire logic               slave_arb_lost,
    input  wire logic               slave_read_done,
    input  wire logic               slave_bus_lost,
    input  wire logic               slave_read_cmd_write,
    input  wire logic               abort_cause_clr,
    // slave receiver byte handling
    input  wire logic               slave_rx_role,
    input  wire logic               rx_byte_done,
    input  wire logic               core_ack,
    input  wire logic               scl_in,
    output logic                    ack_sda_out,
    output logic                    ack_sda_oe_n,
    output logic                    rx_push,
    output logic                    nack_abort,
    // queue levels and dma requests
    input  wire logic [LEVEL_W-1:0] tx_level,
    input  wire logic [LEVEL_W-1:0] rx_level,
    output logic                    tx_flush,
    output logic                    tx_dma_req,
    output logic                    rx_dma_req,
    // interrupts
    output logic                    tx_abort_irq,
    output logic                    irq
);

    // address decode shared by read and write
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] w;
        w = {a[ADDR_W-1:2], 2'h0};
        addr_mapped = (w == OFS_ABORT_CAUSE) || (w == OFS_FORCE_NACK) || (w == OFS_DMA_EN) ||
                      (w == OFS_TX_WM) || (w == OFS_RX_WM) || (w == OFS_IRQ_STATUS) ||
                      (w == OFS_IRQ_MASK);
    endfunction

    logic [CAUSE_MSB:CAUSE_LSB] abort_cause;
    logic [CAUSE_MSB:CAUSE_LSB] cause_event;
    logic [CAUSE_MSB:CAUSE_LSB] next_abort_cause;
    logic                       slave_force_nack;
    logic [1:0]                 dma_channel_enable;
    logic [WM_W-1:0]            tx_dma_watermark;
    logic [WM_W-1:0]            rx_dma_watermark;
    logic [IRQ_W-1:0]           irq_status;
    logic [IRQ_W-1:0]           irq_mask;
    logic [IRQ_W-1:0]           irq_event;
    logic [IRQ_W-1:0]           next_irq_status;
    logic [ADDR_W-1:0]          aw_addr;
    logic [31:0]                w_data;
    logic                       w_low_lane;
    logic                       do_write;
    logic [ADDR_W-1:0]          wr_word;
    logic [ADDR_W-1:0]          rd_word;
    logic [31:0]                rd_value;
    logic                       wr_force_nack;
    logic                       wr_dma_en;
    logic                       wr_tx_wm;
    logic                       wr_rx_wm;
    logic                       wr_irq_status;
    logic                       wr_irq_mask;
    logic                       scl_meta;
    logic                       scl_sync;
    logic                       scl_prev;
    logic                       scl_rise;
    logic                       scl_fall;
    logic                       forced_nack;
    logic                       stale_tx;
    ianc_ack_state_type         ack_state;

    // write channel: take address and data in either order
    assign do_write      = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_word       = {aw_addr[ADDR_W-1:2], 2'h0};
    assign wr_force_nack = do_write && w_low_lane && (wr_word == OFS_FORCE_NACK);
    assign wr_dma_en     = do_write && w_low_lane && (wr_word == OFS_DMA_EN);
    assign wr_tx_wm      = do_write && w_low_lane && (wr_word == OFS_TX_WM);
    assign wr_rx_wm      = do_write && w_low_lane && (wr_word == OFS_RX_WM);
    assign wr_irq_status = do_write && w_low_lane && (wr_word == OFS_IRQ_STATUS);
    assign wr_irq_mask   = do_write && w_low_lane && (wr_word == OFS_IRQ_MASK);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            aw_addr       <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr       <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b1;
            w_data       <= '0;
            w_low_lane   <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_data       <= s_axi_wdata;
            w_low_lane   <= s_axi_wstrb[0];
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read channel: answer one cycle after the address is taken
    assign rd_word = {s_axi_araddr[ADDR_W-1:2], 2'h0};

    always_comb begin
        rd_value = 32'h0000_0000;
        if (rd_word == OFS_ABORT_CAUSE) begin
            rd_value[CAUSE_MSB:CAUSE_LSB] = abort_cause;
        end else if (rd_word == OFS_FORCE_NACK) begin
            rd_value[BIT_FORCE_NACK] = slave_force_nack;
        end else if (rd_word == OFS_DMA_EN) begin
            rd_value[1:0] = dma_channel_enable;
        end else if (rd_word == OFS_TX_WM) begin
            rd_value[WM_W-1:0] = tx_dma_watermark;
        end else if (rd_word == OFS_RX_WM) begin
            rd_value[WM_W-1:0] = rx_dma_watermark;
        end else if (rd_word == OFS_IRQ_STATUS) begin
            rd_value[IRQ_W-1:0] = irq_status;
        end else if (rd_word == OFS_IRQ_MASK) begin
            rd_value[IRQ_W-1:0] = irq_mask;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_value;
            s_axi_rresp   <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slave_force_nack   <= RST_FORCE_NACK;
            dma_channel_enable <= RST_DMA_EN;
            tx_dma_watermark   <= RST_WM;
            rx_dma_watermark   <= RST_WM;
            irq_mask           <= RST_IRQ;
        end else begin
            if (wr_force_nack) begin
                slave_force_nack <= w_data[BIT_FORCE_NACK];
            end
            if (wr_dma_en) begin
                dma_channel_enable <= w_data[1:0];
            end
            if (wr_tx_wm) begin
                tx_dma_watermark <= w_data[WM_W-1:0];
            end
            if (wr_rx_wm) begin
                rx_dma_watermark <= w_data[WM_W-1:0];
            end
            if (wr_irq_mask) begin
                irq_mask <= w_data[IRQ_W-1:0];
            end
        end
    end

    // abort cause events
    assign stale_tx = slave_read_req && (tx_level != '0);
    assign cause_event[BIT_TEN_BIT_RD]  = ten_bit_read_req && !repeated_start_allow;
    assign cause_event[BIT_MST_OFF]     = master_start_req && !master_enable;
    assign cause_event[BIT_ARB_LOST]    = master_arb_lost || slave_bus_lost;
    assign cause_event[BIT_STALE_FLUSH] = stale_tx;
    assign cause_event[BIT_SLV_ARB]     = slave_arb_lost || slave_bus_lost;
    assign cause_event[BIT_SLV_RD_DONE] = slave_read_done;
    assign cause_event[BIT_SLV_BUS]     = slave_bus_lost;
    assign cause_event[BIT_SLV_CMD_WR]  = slave_read_cmd_write;
    assign next_abort_cause = (abort_cause & ~{(CAUSE_MSB-CAUSE_LSB+1){abort_cause_clr}}) | cause_event;

    // interrupt status, write one to clear, set wins
    assign irq_event[BIT_IRQ_ABORT] = |cause_event;
    assign irq_event[BIT_IRQ_NACK]  = forced_nack;
    assign next_irq_status = (irq_status & ~(wr_irq_status ? w_data[IRQ_W-1:0] : RST_IRQ)) | irq_event;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            abort_cause  <= RST_ABORT_CAUSE;
            irq_status   <= RST_IRQ;
            tx_abort_irq <= 1'b0;
            tx_flush     <= 1'b0;
            irq          <= 1'b0;
        end else begin
            abort_cause  <= next_abort_cause;
            irq_status   <= next_irq_status;
            tx_abort_irq <= |next_abort_cause;
            tx_flush     <= stale_tx;
            irq          <= |(next_irq_status & irq_mask);
        end
    end

    // scl pin synchroniser and edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
        end else begin
            scl_meta <= scl_in;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
        end
    end
    assign scl_rise = scl_sync && !scl_prev;
    assign scl_fall = !scl_sync && scl_prev;

    assign forced_nack = rx_byte_done && slave_rx_role && slave_force_nack;

    // acknowledge slot: drive decision until the ninth clock falls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ack_state    <= ACK_IDLE;
            ack_sda_out  <= 1'b1;
            ack_sda_oe_n <= 1'b1;
            rx_push      <= 1'b0;
            nack_abort   <= 1'b0;
        end else begin
            rx_push    <= 1'b0;
            nack_abort <= 1'b0;
            case (ack_state)
                ACK_IDLE: begin
                    if (rx_byte_done) begin
                        ack_state <= ACK_WAIT_HIGH;
                        if (forced_nack) begin
                            ack_sda_out  <= 1'b1;
                            ack_sda_oe_n <= 1'b1;
                            nack_abort   <= 1'b1;
                        end else begin
                            ack_sda_out  <= !core_ack;
                            ack_sda_oe_n <= !core_ack;
                            rx_push      <= core_ack;
                        end
                    end
                end
                ACK_WAIT_HIGH: begin
                    if (scl_rise) begin
                        ack_state <= ACK_WAIT_LOW;
                    end
                end
                ACK_WAIT_LOW: begin
                    if (scl_fall) begin
                        ack_state    <= ACK_IDLE;
                        ack_sda_out  <= 1'b1;
                        ack_sda_oe_n <= 1'b1;
                    end
                end
                default: begin
                    ack_state <= ACK_IDLE;
                end
            endcase
        end
    end

    // dma request watermarks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_dma_req <= 1'b0;
            rx_dma_req <= 1'b0;
        end else begin
            tx_dma_req <= dma_channel_enable[BIT_TX_DMA_ON] && (tx_level <= LEVEL_W'(tx_dma_watermark));
            rx_dma_req <= dma_channel_enable[BIT_RX_DMA_ON] && (rx_level > LEVEL_W'(rx_dma_watermark));
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_ten_bit_read;
        ten_bit_read_req && !repeated_start_allow |=> abort_cause[BIT_TEN_BIT_RD] && tx_abort_irq;
    endproperty
    a_ten_bit_read: assert property (p_ten_bit_read) else $error("ten-bit read cause not set");

    property p_master_off;
        master_start_req && !master_enable |=> abort_cause[BIT_MST_OFF];
    endproperty
    a_master_off: assert property (p_master_off) else $error("master-off cause not set");

    property p_slave_bus_lost;
        slave_bus_lost |=> abort_cause[BIT_SLV_BUS] && abort_cause[BIT_SLV_ARB] && abort_cause[BIT_ARB_LOST];
    endproperty
    a_slave_bus_lost: assert property (p_slave_bus_lost) else $error("bus-lost causes not set together");

    property p_stale_flush;
        slave_read_req && (tx_level != '0) |=> tx_flush && tx_abort_irq && abort_cause[BIT_STALE_FLUSH];
    endproperty
    a_stale_flush: assert property (p_stale_flush) else $error("stale data flush missing");

    property p_read_done;
        slave_read_done && !abort_cause_clr |=> abort_cause[BIT_SLV_RD_DONE] [*1] ##1 1'b1;
    endproperty
    a_read_done: assert property (p_read_done) else $error("read done cause not set");

    property p_forced_nack;
        ack_state == ACK_IDLE && rx_byte_done && slave_rx_role && slave_force_nack
            |=> nack_abort && !rx_push && ack_sda_oe_n ##1 !nack_abort;
    endproperty
    a_forced_nack: assert property (p_forced_nack) else $error("forced nack not applied");

    property p_role_gate;
        ack_state == ACK_IDLE && rx_byte_done && !slave_rx_role && core_ack |=> !nack_abort && rx_push && !ack_sda_oe_n;
    endproperty
    a_role_gate: assert property (p_role_gate) else $error("nack outside slave receiver role");

    property p_tx_dma_off;
        !dma_channel_enable[BIT_TX_DMA_ON] ##1 !dma_channel_enable[BIT_TX_DMA_ON] |-> !tx_dma_req;
    endproperty
    a_tx_dma_off: assert property (p_tx_dma_off) else $error("tx dma request while disabled");

    property p_rx_level;
        rx_dma_req |-> $past(rx_level) > LEVEL_W'($past(rx_dma_watermark));
    endproperty
    a_rx_level: assert property (p_rx_level) else $error("rx dma request below watermark");

    property p_read_zero;
        s_axi_rvalid |-> s_axi_rdata[31:CAUSE_MSB+1] == '0;
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("upper read bits not zero");

    property p_write_answer;
        do_write |=> s_axi_bvalid ##0 (s_axi_bvalid throughout (!s_axi_awready [*1]));
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write response missing");

endmodule
`default_nettype wire

// file: ianc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module ianc_far_model (
    // frame request from the bench
    input  wire logic frame,
    // bus clock pin, pulled up outside frames
    output var logic  scl
);
    // dma beat width 16 or 32
    localparam int DMA_BEAT_W = 32;
    initial begin
        scl = 1'b1;
        #1.3;
        forever begin
            #80;
            scl = frame ? ~scl : 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: test_i2c_abort_nack_dma_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_i2c_abort_nack_dma_ctrl;
    import ianc_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr, araddr, ev, cx [8];
    logic [31:0] wdata, rdata, r, q[$];
    logic [1:0]  bresp, rresp;
    logic        rsa, men, clr, role, rbd, cack, scl, frame, sda, oe_n, push, nab, flush, txr, rxr, tirq, irq;
    logic [3:0]  txl, rxl;
    int          err_total = 0, compares = 0, seed = 32740, i;
    ianc_far_model i_ianc_far_model (.frame(frame), .scl(scl));
    ianc_ctrl i_ianc_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .repeated_start_allow(rsa), .master_enable(men), .ten_bit_read_req(ev[0]),
        .master_start_req(ev[1]), .master_arb_lost(ev[2]), .slave_read_req(ev[3]), .slave_arb_lost(ev[4]),
        .slave_read_done(ev[5]), .slave_bus_lost(ev[6]), .slave_read_cmd_write(ev[7]), .abort_cause_clr(clr),
        .slave_rx_role(role), .rx_byte_done(rbd), .core_ack(cack), .scl_in(scl), .ack_sda_out(sda),
        .ack_sda_oe_n(oe_n), .rx_push(push), .nack_abort(nab), .tx_level(txl), .rx_level(rxl),
        .tx_flush(flush), .tx_dma_req(txr), .rx_dma_req(rxr), .tx_abort_irq(tirq), .irq(irq));
    task end_sim;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        if (n == 50) begin err_total++; end_sim; end
        chk(bresp, RESP_OKAY);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        int n;
        n = 0;
        q.push_back(x);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        if (n == 50) begin err_total++; end_sim; end
        chk(rresp, (a == 8'h40) ? RESP_SLVERR : RESP_OKAY);
    endtask
    task slot(input logic rl, input logic ak);
        @(posedge aclk);
        role <= rl;
        cack <= ak;
        rbd <= 1'b1;
        @(posedge aclk);
        rbd <= 1'b0;
        #1;
    endtask
    task frm;
        frame = 1'b1;
        #400;
        frame = 1'b0;
        repeat (20) @(posedge aclk);
        #1;
    endtask
    // read data scoreboard
    always @(posedge aclk) if (rvalid === 1'b1) chk(rdata, q.pop_front());
    initial begin aclk = 1'b0; forever #2.5 aclk = ~aclk; end
    initial begin repeat (100000) @(posedge aclk); err_total++; end_sim; end
    initial begin
        {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata, ev, rsa, men, clr, role, rbd, cack} = '0;
        {bready, rready, frame, txl, rxl} = {3'h6, 8'h0};
        cx = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h54, 8'h80};
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_FORCE_NACK, 0); rd(OFS_DMA_EN, 0); rd(OFS_TX_WM, 0); rd(OFS_RX_WM, 0);
        wr(OFS_ABORT_CAUSE, 32'hffff_ffff); rd(OFS_ABORT_CAUSE, 0); rd(8'h40, 0);
        $display("test reset done");
        txl <= 4'h5;
        for (i = 0; i < 8; i++) begin
            wr(OFS_IRQ_MASK, {31'h0, i != 7});
            @(posedge aclk) ev <= 8'h1 << i;
            @(posedge aclk) ev <= 8'h0;
            #1 chk(flush, i == 3);
            chk(tirq, 1);
            rd(OFS_ABORT_CAUSE, {16'h0, cx[i], 8'h0});
            chk(irq, i != 7);
            @(posedge aclk) clr <= 1'b1;
            @(posedge aclk) clr <= 1'b0;
            wr(OFS_IRQ_STATUS, 32'h3);
            repeat (2) @(posedge aclk);
            #1 chk({tirq, irq}, 0);
        end
        @(posedge aclk) {rsa, men, ev} <= {2'h3, 8'h03};
        @(posedge aclk) ev <= 8'h0;
        #1 chk(tirq, 0);
        rd(OFS_ABORT_CAUSE, 0);
        $display("test abort causes done");
        for (i = 0; i < 16; i++) begin
            r = $random(seed);
            wr(OFS_TX_WM, {29'h0, r[2:0]}); wr(OFS_RX_WM, {29'h0, r[5:3]}); wr(OFS_DMA_EN, {30'h0, r[7:6]});
            rd(OFS_RX_WM, {29'h0, r[5:3]});
            @(posedge aclk) {rxl, txl} <= r[15:8];
            repeat (3) @(posedge aclk);
            #1 chk(txr, r[7] && r[11:8] <= {1'b0, r[2:0]});
            chk(rxr, r[6] && r[15:12] > {1'b0, r[5:3]});
        end
        $display("test dma done");
        @(posedge aclk) aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        #1 chk({txr, rxr}, 0);
        rd(OFS_DMA_EN, 0); rd(OFS_TX_WM, 0);
        $display("test second reset done");
        wr(OFS_FORCE_NACK, 1); rd(OFS_FORCE_NACK, 1); slot(1, 1);
        chk({nab, push, oe_n}, 3'h5);
        rd(OFS_IRQ_STATUS, 32'h2);
        frm; slot(0, 1);
        chk({nab, push, oe_n, sda}, 4'h4);
        frm;
        chk(oe_n, 1);
        wr(OFS_FORCE_NACK, 0); slot(1, 0);
        chk({nab, push, oe_n}, 3'h1);
        frm; slot(1, 1);
        chk({nab, push, oe_n}, 3'h2);
        frm;
        $display("test force nack done");
        end_sim;
    end
endmodule
`default_nettype wire
